//--- pkg/serial_dac_pkg.sv
// types for the serial converter write port
// assumes serial_dac_regs.svh on the include path
`include "serial_dac_regs.svh"

package serial_dac_pkg;

    typedef enum logic [1:0] {
        mode_normal,
        mode_gnd_1k,
        mode_gnd_100k,
        mode_high_z
    } pd_mode_t;

    typedef enum logic [1:0] {
        st_idle,
        st_shift,
        st_done
    } frame_state_t;

endpackage : serial_dac_pkg

//--- pkg/serial_dac_regs.svh
// constants for the serial converter write port
// assumes inclusion by bare name from the design package
`ifndef SERIAL_DAC_REGS_SVH
`define SERIAL_DAC_REGS_SVH

`define FRAME_BITS        24
`define FRAME_CNT_W       5
`define CODE_BITS         16
`define CODE_MSB          15
`define MODE_HI_POS       17
`define MODE_LO_POS       16
`define CODE_RESET        16'h0000
`define SCLK_MAX_HZ       30000000
`define SYNC_HIGH_MIN_NS  33
`define CLK_SYS_HZ        40000000

`endif

//--- pkg/word_buf_if.sv
// handshake bundle between frame decoder and word buffer
// assumes one clock domain on both sides
`timescale 1ns/100ps

interface word_buf_if #(parameter int W = 18);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : word_buf_if

//--- tb/host_model.sv
// serial master model driving the three pins
// assumes drive at falling clk_sys, sclk 200 ns period
`timescale 1ns/100ps

module host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic     sclk,
    output logic     sync_n,
    output logic     din
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // ==========================================
    // frame of n bits, cut short when n below 24
    task send(input logic [23:0] w, input int n);
        int i;
        @(negedge clk_sys);
        sync_n = 1'b1;
        din = ~din;
        repeat (3) @(negedge clk_sys);
        sync_n = 1'b0;
        for (i = 23; i > 23 - n; i--) begin
            repeat (3) @(negedge clk_sys);
            din = w[i];
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
            @(negedge clk_sys);
        end
        if (n < 24) begin
            sync_n = 1'b1;
            din = ~din;
        end
        // full frame rests select low
    endtask : send
    // stray clocks with select low
    task clocks(input int n);
        repeat (n) begin
            din = ~din;
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
    endtask : clocks
endmodule : host_model

//--- tb/serial_dac_monitor.sv
// checker on the serial write port outputs
// assumes bind onto serial_dac_write_port, one clock domain
`timescale 1ns/100ps

module serial_dac_monitor
    import serial_dac_pkg::*;
(
    // clock and reset
    input wire logic                     clk_sys,
    input wire logic                     srst,
    // serial pins
    input wire logic                     sclk,
    input wire logic                     sync_n,
    input wire logic                     din,
    // converter side
    input wire logic [15:0]              dac_code,
    input wire serial_dac_pkg::pd_mode_t pd_mode,
    input wire logic                     amp_enable,
    input wire logic                     update_pulse,
    input wire logic                     frame_abort,
    input wire logic                     busy
);
    import serial_dac_pkg::*;
    // ==========================================
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_outcome; ##[0:3] (update_pulse || frame_abort); endsequence
    property p_amp; amp_enable == (pd_mode == mode_normal); endproperty
    property p_code; $changed(dac_code) |-> update_pulse; endproperty
    property p_mode; $changed(pd_mode) |-> update_pulse; endproperty
    property p_pulse; update_pulse |=> !update_pulse && !frame_abort; endproperty
    property p_abort; frame_abort |-> !update_pulse ##1 !frame_abort; endproperty
    property p_end; $fell(busy) |-> s_outcome; endproperty
    property p_start; $fell(sync_n) |-> ##[1:5] busy; endproperty
    property p_idle; sync_n [*6] |-> !busy; endproperty
    a_amp: assert property (p_amp) else $error("amp enable wrong");
    a_code: assert property (p_code) else $error("code moved alone");
    a_mode: assert property (p_mode) else $error("mode moved alone");
    a_pulse: assert property (p_pulse) else $error("update too long");
    a_abort: assert property (p_abort) else $error("abort too long");
    a_end: assert property (p_end) else $error("frame end unseen");
    a_start: assert property (p_start) else $error("frame not armed");
    a_idle: assert property (p_idle) else $error("busy while idle");
endmodule : serial_dac_monitor

bind serial_dac_write_port serial_dac_monitor u_mon (.clk_sys, .srst, .sclk, .sync_n,
    .din, .dac_code, .pd_mode, .amp_enable, .update_pulse, .frame_abort, .busy);

//--- tb/serial_dac_write_port_tb.sv
// self-checking bench for the serial write port
// assumes host_model and the bound checker
`timescale 1ns/100ps

module serial_dac_write_port_tb;
    import serial_dac_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sclk, sync_n, din, amp_enable, update_pulse, frame_abort, busy;
    logic [15:0] dac_code;
    pd_mode_t    pd_mode;
    int          bad_count = 0;
    int          total_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    serial_dac_write_port dut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
        .sync_n(sync_n), .din(din), .dac_code(dac_code), .pd_mode(pd_mode),
        .amp_enable(amp_enable), .update_pulse(update_pulse),
        .frame_abort(frame_abort), .busy(busy));
    host_model host (.clk_sys(clk_sys), .sclk(sclk), .sync_n(sync_n), .din(din));
    // ==========================================
    // helpers
    task chk(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wait_ev(input bit ab);
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if ((ab ? frame_abort : update_pulse) === 1'b1) break;
        end
        chk(i < 40, 1'b1);
        if (i >= 40) close_out();
    endtask : wait_ev
    task close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // ==========================================
    // scenarios
    task t_reset();
        chk({pd_mode, dac_code}, {2'h0, 16'h0000});
        chk({amp_enable, busy}, 2'h2);
    endtask : t_reset
    task t_modes();
        logic [15:0] codes [4];
        int m;
        codes = '{16'hFFFF, 16'h0000, 16'h8001, 16'h1234};
        for (m = 0; m < 4; m++) begin
            host.send({6'h2A, m[1:0], codes[m]}, 24);
            wait_ev(1'b0);
            chk({pd_mode, dac_code}, {m[1:0], codes[m]});
            chk(amp_enable, m == 0);
        end
    endtask : t_modes
    task t_abort();
        host.send({6'h00, 2'h1, 16'h5A5A}, 23);
        wait_ev(1'b1);
        chk({pd_mode, dac_code}, {2'h3, 16'h1234});
    endtask : t_abort
    task t_extra();
        host.send({6'h3F, 2'h0, 16'hC3C3}, 24);
        wait_ev(1'b0);
        host.clocks(24);
        chk({pd_mode, dac_code}, {2'h0, 16'hC3C3});
        chk(busy, 1'b0);
    endtask : t_extra
    initial begin
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_modes();
        t_abort();
        t_extra();
        close_out();
    end
endmodule : serial_dac_write_port_tb

//--- verilog/serial_dac_write_port.sv
// three-wire serial write port of a 16-bit voltage-output converter
// assumes sclk, sync_n and din are asynchronous pins sampled by clk_sys
//
// Function
// - data sampled on each of the first 24 falling serial clock edges while select low
// - 24th falling edge completes frame and executes its command
// - after 24th edge, select may stay low or rise freely
// - frame: six ignored bits, two mode bits, sixteen code bits
// - frames travel most significant bit first
// - select rising before 24th edge aborts frame, nothing changes
// - code register is zero from reset until a valid frame
// - frame bits 17 and 16 select normal or three power-down modes
// - a power-down frame still loads its sixteen code bits into the code register
// - code is straight unsigned binary, output proportional to code/65536
`timescale 1ns/100ps
`include "serial_dac_regs.svh"

module serial_dac_write_port
    import serial_dac_pkg::*;
#(
    parameter int FRAME_BITS = `FRAME_BITS
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    // serial pins
    input  wire logic                 sclk,
    input  wire logic                 sync_n,
    input  wire logic                 din,
    // converter side
    output logic [`CODE_MSB:0]        dac_code,
    output serial_dac_pkg::pd_mode_t  pd_mode,
    output logic                      amp_enable,
    output logic                      update_pulse,
    output logic                      frame_abort,
    output logic                      busy
);

    import serial_dac_pkg::*;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [1:0] sclk_s_q, sync_s_q, din_s_q;
    logic       sclk_d1_q, sync_d1_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sclk_s_q  <= 2'h0;
            sync_s_q  <= 2'h3;
            din_s_q   <= 2'h0;
            sclk_d1_q <= 1'b0;
            sync_d1_q <= 1'b1;
        end else begin
            sclk_s_q  <= {sclk_s_q[0], sclk};
            sync_s_q  <= {sync_s_q[0], sync_n};
            din_s_q   <= {din_s_q[0], din};
            sclk_d1_q <= sclk_s_q[1];
            sync_d1_q <= sync_s_q[1];
        end
    end

    wire sclk_fall = sclk_d1_q && !sclk_s_q[1];
    wire sync_fall = sync_d1_q && !sync_s_q[1];
    wire sync_low  = !sync_s_q[1];
    wire din_now   = din_s_q[1];

    // ==========================================================
    // frame shifter
    // ==========================================================
    frame_state_t            st_q, st_d;
    logic [FRAME_BITS-1:0]   shift_q, shift_d;
    logic [`FRAME_CNT_W-1:0] cnt_q, cnt_d;
    logic                    push_v, abort_d, abort_q;
    logic [FRAME_BITS-1:0]   frame_w;

    word_buf_if #(.W(`CODE_BITS + 2)) wb_if ();

    always_comb begin
        st_d    = st_q;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        push_v  = 1'b0;
        abort_d = 1'b0;
        frame_w = {shift_q[FRAME_BITS-2:0], din_now};
        unique case (st_q)
            st_idle: begin
                if (sync_fall) begin
                    st_d    = st_shift;
                    shift_d = '0;
                    cnt_d   = '0;
                end
            end
            st_shift: begin
                if (!sync_low) begin
                    st_d    = st_idle;
                    shift_d = '0;
                    cnt_d   = '0;
                    abort_d = 1'b1;
                end else if (sclk_fall && wb_if.ready) begin
                    shift_d = frame_w;
                    cnt_d   = `FRAME_CNT_W'(cnt_q + 1'b1);
                    if (cnt_q == `FRAME_CNT_W'(FRAME_BITS - 1)) begin
                        push_v = 1'b1;
                        st_d   = st_done;
                    end
                end
            end
            st_done: begin
                if (!sync_low) begin
                    st_d = st_idle;
                end
            end
        endcase
    end

    // bits 23..18 ignored; 17..16 mode; 15..0 code
    assign wb_if.valid = push_v;
    assign wb_if.data  = frame_w[`MODE_HI_POS:0];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q    <= st_idle;
            shift_q <= '0;
            cnt_q   <= '0;
            abort_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            abort_q <= abort_d;
        end
    end

    // ==========================================================
    // word buffer and command execution
    // ==========================================================
    logic                  cmd_valid;
    logic [`CODE_BITS+1:0] cmd_data;

    word_buf2 #(.W(`CODE_BITS + 2)) u_buf (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_if     (wb_if),
        .out_valid (cmd_valid),
        .out_ready (1'b1),
        .out_data  (cmd_data)
    );

    logic [`CODE_MSB:0] code_q, code_d;
    pd_mode_t           mode_q, mode_d;
    logic               upd_q, upd_d;

    always_comb begin
        code_d = code_q;
        mode_d = mode_q;
        upd_d  = 1'b0;
        if (cmd_valid) begin
            code_d = cmd_data[`CODE_MSB:0];
            mode_d = pd_mode_t'({cmd_data[`MODE_HI_POS],
                                 cmd_data[`MODE_LO_POS]});
            upd_d  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code_q <= `CODE_RESET;
            mode_q <= mode_normal;
            upd_q  <= 1'b0;
        end else begin
            code_q <= code_d;
            mode_q <= mode_d;
            upd_q  <= upd_d;
        end
    end

    assign dac_code     = code_q;
    assign pd_mode      = mode_q;
    assign amp_enable   = (mode_q == mode_normal);
    assign update_pulse = upd_q;
    assign frame_abort  = abort_q;
    assign busy         = (st_q == st_shift);

endmodule : serial_dac_write_port

//--- verilog/word_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes single clock, synchronous active-high reset
`timescale 1ns/100ps

module word_buf2 #(
    parameter int W = 18
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // filling side
    word_buf_if.snk   in_if,
    // draining side
    output logic         out_valid,
    input  wire logic    out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] slot_q [2];
    logic [W-1:0] slot_d [2];
    logic [1:0]   cnt_q;
    logic [1:0]   cnt_d;

    wire push = in_if.valid && in_if.ready;
    wire pop  = out_valid && out_ready;

    assign in_if.ready = (cnt_q != 2'h2);
    assign out_valid   = (cnt_q != 2'h0);
    assign out_data    = slot_q[0];

    always_comb begin
        slot_d = slot_q;
        cnt_d  = cnt_q;
        if (pop) begin
            slot_d[0] = slot_q[1];
        end
        if (push) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                slot_d[0] = in_if.data;
            end else begin
                slot_d[1] = in_if.data;
            end
        end
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q     <= 2'h0;
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end else begin
            cnt_q  <= cnt_d;
            slot_q <= slot_d;
        end
    end

endmodule : word_buf2
